//--- design/dss_pkg.sv
// Shared constants, types and carriers for the digital sound status readout
package dss_pkg;
    // Subaddresses of the readout bank
    localparam logic [7:0] SUB_STATUS = 8'h01;
    localparam logic [7:0] SUB_ERR = 8'h02;
    localparam logic [7:0] SUB_AUX_LO = 8'h03;
    localparam logic [7:0] SUB_AUX_HI = 8'h04;
    localparam logic [7:0] SUB_LVL_HI = 8'h05;
    localparam logic [7:0] SUB_LVL_LO = 8'h06;
    localparam logic [7:0] SUB_SIF = 8'h07;
    localparam logic [7:0] SUB_UNMAPPED_VALUE = 8'h00;

    // Field positions
    localparam int STAT_CTRL_LSB = 4;
    localparam int STAT_SYNC_BIT = 3;
    localparam int STAT_CFG_BIT = 2;
    localparam int STAT_STEREO_BIT = 1;
    localparam int STAT_DUAL_BIT = 0;
    localparam int CTRL_C3_IDX = 2;
    localparam int CTRL_C4_IDX = 3;
    localparam int AUXH_OVW_BIT = 7;
    localparam int AUXH_NEW_BIT = 6;
    localparam int SIF_PILOT_BIT = 7;

    // Reset values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic FALLBACK_RESET = 1'b1;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int ERR_PERIOD_MS = 128;
    localparam int ERR_PERIOD_CYCLES = ERR_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int TMR_W = 24;

    // Widths
    localparam int AUDIO_W = 16;
    localparam int AUX_W = 11;
    localparam int PARITY_N = 10;
    localparam logic [7:0] ERR_MAX = 8'hff;

    typedef enum logic [2:0] {BUS_IDLE, BUS_RX, BUS_ACK, BUS_TX, BUS_MACK, BUS_WAIT} dss_bus_st_t;

    typedef struct packed {
        logic [3:0] ctrl;
        logic frame_lock;
        logic mf_lock;
        logic cfg_change;
        logic stereo;
        logic dual;
    } dss_frame_t;

    typedef struct packed {
        logic valid;
        logic [AUX_W-1:0] word;
        logic [PARITY_N-1:0] parity_a;
        logic [PARITY_N-1:0] parity_b;
    } dss_aux_t;

    typedef struct packed {
        logic agc_on;
        logic [4:0] agc_level;
        logic [4:0] gain_reg;
        logic pilot;
    } dss_fe_t;

    typedef struct packed {
        dss_bus_st_t st;
        logic scl_q;
        logic sda_q;
        logic [2:0] cnt;
        logic full;
        logic [7:0] sh;
        logic [7:0] sub;
        logic [1:0] idx;
        logic rw;
        logic oe;
        logic [7:0] status;
        logic [7:0] err_cnt;
        logic [7:0] err_reg;
        logic [TMR_W-1:0] tmr;
        logic [AUX_W-1:0] aux;
        logic [1:0] ci;
        logic new_data;
        logic overwrite_flag;
        logic [15:0] lvl;
        logic [7:0] sif;
        logic [AUDIO_W-1:0] audio;
        logic fallback;
        logic reserve;
    } dss_state_t;
endpackage

//--- design/dss_majority.sv
// Majority vote over a group of parity check results
`timescale 1ns/100ps
module dss_majority
    import dss_pkg::*;
#(
    parameter int N = PARITY_N
) (
    input wire logic [N-1:0] votes,
    output logic decision
);
    if (N < 1) begin : g_bad_n
        $error("dss_majority needs at least one vote");
    end

    always_comb begin
        int unsigned ones;
        ones = 0;
        for (int i = 0; i < N; i++) begin
            ones = ones + 32'(votes[i]);
        end
        // Strictly more than half; a tie reads as zero
        decision = (ones * 2) > N;
    end
endmodule

//--- design/dss_readout.sv
// Digital sound status readout bank behind the two-wire control bus
//
// Notes on behaviour
// [R1] Status bits 7..4 carry received control bits C4..C1, C4 on top.
// [R2] Sync bit 3 set only with both frame and 16-frame multiframe lock.
// [R3] Without sync the digital sound path outputs silence.
// [R4] Config-change bit 2 set when configuration changes at a multiframe boundary.
// [R5] Status bit 1 shows stereo mode.
// [R6] Status bit 0 shows dual mono mode.
// [R7] Control bit C3 high selects first carrier programme, ignoring auto fallback setting.
// [R8] Loss of sync selects first carrier programme, ignoring auto fallback setting.
// [R9] Errors are counted per 128 ms; error register refreshed each period.
// [R10] Subaddress 3 returns aux word bits 7..0.
// [R11] Subaddress 4 bits 2..0 return aux word bits 10..8.
// [R12] Overwrite flag set when a new aux word lands before the last was read.
// [R13] New-data flag set on a new aux word, cleared by reading aux data.
// [R14] Two coding indicators come from majority over ten parity checks.
// [R15] Monitor word: high byte at subaddress 5, low byte at 6.
// [R16] Word sign bit sits in bit 7 of high byte, LSB in bit 0 of low.
// [R17] With level AGC on, subaddress 7 bits 4..0 show measured input level.
// [R18] With level AGC off, subaddress 7 returns the gain setting register.
// [R19] Pilot presence shows in bit 7 of subaddress 7 with no extra delay.
// [R20] Host should ignore pilot flag while tuned to digital carrier frequencies.
// [R21] Aux-high bit 5 and level bits 6..5 are undefined and read zero.
// [R22] Reads are slave transmitter with subaddress auto increment until not-acknowledge.
// [R23] Reserve switching flag mirrors received control bit C4.
// [R24] Reading either aux byte clears new-data and overwrite after the byte.
`timescale 1ns/100ps
module dss_readout
    import dss_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h5b,
    parameter int ERR_PERIOD = ERR_PERIOD_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire dss_frame_t frame_in,
    input wire logic sound_error,
    input wire dss_aux_t aux_in,
    input wire logic [15:0] level_word,
    input wire dss_fe_t fe_in,
    input wire logic [AUDIO_W-1:0] audio_in,
    input wire logic auto_fallback_config,
    input wire logic auto_mute_req,
    output logic [AUDIO_W-1:0] audio_out,
    output logic fallback_select,
    output logic reserve_switch_flag
);
    if (ERR_PERIOD < 2 || ERR_PERIOD > (2 ** TMR_W)) begin : g_bad_period
        $error("dss_readout error period does not fit the timer");
    end

    dss_state_t s_reg;
    dss_state_t s_next;
    logic ci_a;
    logic ci_b;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic rd_evt;
    logic [7:0] rd_sub;
    logic period_end;
    logic sync_now;
    logic [1:0] ci_ref;

    dss_majority #(.N(PARITY_N)) u_ci_a ( // R14
        .votes(aux_in.parity_a),
        .decision(ci_a)
    );

    dss_majority #(.N(PARITY_N)) u_ci_b ( // R14
        .votes(aux_in.parity_b),
        .decision(ci_b)
    );

    // Byte presented for a subaddress
    function automatic logic [7:0] read_byte(input logic [7:0] sub, input dss_state_t s);
        logic [7:0] b;
        b = SUB_UNMAPPED_VALUE;
        if (sub == SUB_STATUS) begin
            b = s.status;
        end else if (sub == SUB_ERR) begin
            b = s.err_reg;
        end else if (sub == SUB_AUX_LO) begin
            b = s.aux[7:0]; // R10
        end else if (sub == SUB_AUX_HI) begin
            b = {s.overwrite_flag, s.new_data, 1'b0, s.ci, s.aux[AUX_W-1:8]}; // R11 R21
        end else if (sub == SUB_LVL_HI) begin
            b = s.lvl[15:8]; // R15 R16
        end else if (sub == SUB_LVL_LO) begin
            b = s.lvl[7:0]; // R15 R16
        end else if (sub == SUB_SIF) begin
            b = s.sif;
        end
        return b;
    endfunction

    assign scl_rise = scl_in & ~s_reg.scl_q;
    assign scl_fall = ~scl_in & s_reg.scl_q;
    assign bus_start = s_reg.scl_q & scl_in & s_reg.sda_q & ~sda_in;
    assign bus_stop = s_reg.scl_q & scl_in & ~s_reg.sda_q & sda_in;
    assign period_end = s_reg.tmr == TMR_W'(ERR_PERIOD - 1);
    assign sync_now = frame_in.frame_lock & frame_in.mf_lock;
    assign ci_ref = {$countones(aux_in.parity_a) > PARITY_N / 2, $countones(aux_in.parity_b) > PARITY_N / 2};

    always_comb begin
        logic [7:0] nb;
        nb = 8'h00;
        s_next = s_reg;
        rd_evt = 1'b0;
        rd_sub = s_reg.sub;
        s_next.scl_q = scl_in;
        s_next.sda_q = sda_in;

        // Bus engine
        case (s_reg.st)
            BUS_IDLE: begin
                s_next.oe = 1'b0;
            end
            BUS_RX: begin
                if (scl_rise) begin
                    s_next.sh = {s_reg.sh[6:0], sda_in};
                    s_next.cnt = s_reg.cnt + 3'd1;
                    s_next.full = s_reg.cnt == 3'd7;
                end else if (scl_fall && s_reg.full) begin
                    s_next.full = 1'b0;
                    s_next.st = BUS_ACK;
                    s_next.oe = 1'b1;
                    if (s_reg.idx == 2'd0) begin
                        s_next.rw = s_reg.sh[0];
                        if (s_reg.sh[7:1] != SLAVE_ADDR) begin
                            s_next.st = BUS_WAIT;
                            s_next.oe = 1'b0;
                        end
                    end else if (s_reg.idx == 2'd1) begin
                        s_next.sub = s_reg.sh;
                    end else begin
                        // Writable registers live elsewhere; data is acknowledged and skipped
                        s_next.sub = s_reg.sub + 8'd1;
                    end
                end
            end
            BUS_ACK: begin
                if (scl_fall) begin
                    s_next.oe = 1'b0;
                    s_next.cnt = 3'd0;
                    s_next.idx = (s_reg.idx == 2'd2) ? 2'd2 : s_reg.idx + 2'd1;
                    if (s_reg.idx == 2'd0 && s_reg.rw) begin
                        nb = read_byte(s_reg.sub, s_reg); // R22
                        s_next.sh = nb;
                        s_next.oe = ~nb[7];
                        s_next.st = BUS_TX;
                    end else begin
                        s_next.st = BUS_RX;
                    end
                end
            end
            BUS_TX: begin
                if (scl_fall) begin
                    if (s_reg.cnt == 3'd7) begin
                        s_next.oe = 1'b0;
                        s_next.full = 1'b0;
                        s_next.st = BUS_MACK;
                        rd_evt = 1'b1;
                        s_next.sub = s_reg.sub + 8'd1; // R22
                    end else begin
                        s_next.sh = {s_reg.sh[6:0], 1'b0};
                        s_next.oe = ~s_reg.sh[6];
                        s_next.cnt = s_reg.cnt + 3'd1;
                    end
                end
            end
            BUS_MACK: begin
                if (scl_rise) begin
                    s_next.full = ~sda_in;
                    if (sda_in) begin
                        s_next.st = BUS_WAIT; // R22
                    end
                end else if (scl_fall && s_reg.full) begin
                    nb = read_byte(s_reg.sub, s_reg); // R22
                    s_next.sh = nb;
                    s_next.oe = ~nb[7];
                    s_next.cnt = 3'd0;
                    s_next.full = 1'b0;
                    s_next.st = BUS_TX;
                end
            end
            BUS_WAIT: begin
                s_next.oe = 1'b0;
            end
            default: begin
                s_next.st = BUS_IDLE;
                s_next.oe = 1'b0;
            end
        endcase

        if (bus_start) begin
            s_next.st = BUS_RX;
            s_next.cnt = 3'd0;
            s_next.idx = 2'd0;
            s_next.full = 1'b0;
            s_next.oe = 1'b0;
        end else if (bus_stop) begin
            s_next.st = BUS_IDLE;
            s_next.oe = 1'b0;
        end

        // Status byte; clears from reads come first so a new event wins
        if (rd_evt && rd_sub == SUB_STATUS) begin
            s_next.status[STAT_CFG_BIT] = 1'b0;
        end
        if (frame_in.cfg_change) begin
            s_next.status[STAT_CFG_BIT] = 1'b1; // R4
        end
        s_next.status[7:STAT_CTRL_LSB] = frame_in.ctrl; // R1
        s_next.status[STAT_SYNC_BIT] = sync_now; // R2
        s_next.status[STAT_STEREO_BIT] = frame_in.stereo; // R5
        s_next.status[STAT_DUAL_BIT] = frame_in.dual; // R6

        // Error count per period
        if (period_end) begin
            s_next.tmr = '0;
            s_next.err_cnt = 8'h00;
            s_next.err_reg = (sound_error && s_reg.err_cnt != ERR_MAX) ? s_reg.err_cnt + 8'd1 : s_reg.err_cnt; // R9
        end else begin
            s_next.tmr = s_reg.tmr + TMR_W'(1);
            if (sound_error && s_reg.err_cnt != ERR_MAX) begin
                s_next.err_cnt = s_reg.err_cnt + 8'd1; // R9
            end
        end

        // Additional data word and its flags
        if (rd_evt && (rd_sub == SUB_AUX_LO || rd_sub == SUB_AUX_HI)) begin
            s_next.new_data = 1'b0; // R13 R24
            s_next.overwrite_flag = 1'b0; // R24
        end
        if (aux_in.valid) begin
            // Only a word still unread after this cycle's read counts as overwritten
            if (s_next.new_data) begin
                s_next.overwrite_flag = 1'b1; // R12
            end
            s_next.aux = aux_in.word;
            s_next.ci = {ci_a, ci_b}; // R14
            s_next.new_data = 1'b1; // R13
        end

        // Monitor word, input level and pilot
        s_next.lvl = level_word; // R15
        s_next.sif = {fe_in.pilot, 2'b00, fe_in.agc_on ? fe_in.agc_level : fe_in.gain_reg}; // R17 R18 R19 R21

        // Sound path and programme selection
        s_next.audio = sync_now ? audio_in : '0; // R3
        s_next.fallback = frame_in.ctrl[CTRL_C3_IDX] | ~sync_now | (auto_fallback_config & auto_mute_req); // R7 R8
        s_next.reserve = frame_in.ctrl[CTRL_C4_IDX]; // R23
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '{st: BUS_IDLE, scl_q: 1'b1, sda_q: 1'b1, cnt: 3'd0, full: 1'b0, sh: REG_RESET,
                       sub: REG_RESET, idx: 2'd0, rw: 1'b0, oe: 1'b0, status: REG_RESET, err_cnt: REG_RESET,
                       err_reg: REG_RESET, tmr: '0, aux: '0, ci: 2'b00, new_data: 1'b0, overwrite_flag: 1'b0,
                       lvl: 16'h0000, sif: REG_RESET, audio: '0, fallback: FALLBACK_RESET, reserve: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = s_reg.oe;
    assign audio_out = s_reg.audio;
    assign fallback_select = s_reg.fallback;
    assign reserve_switch_flag = s_reg.reserve;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence aux_read_s;
        rd_evt && (rd_sub == SUB_AUX_LO || rd_sub == SUB_AUX_HI) && !aux_in.valid;
    endsequence

    sequence aux_store_unread_s;
        aux_in.valid && s_reg.new_data && !rd_evt;
    endsequence

    sequence tx_last_fall_s;
        s_reg.st == BUS_TX && scl_fall && s_reg.cnt == 3'd7;
    endsequence

    a_sync_needs_lock: assert property (s_reg.status[STAT_SYNC_BIT] |-> $past(sync_now)) // R2
        else $error("sync bit set without both locks");
    a_silence_no_sync: assert property (!s_reg.status[STAT_SYNC_BIT] |-> audio_out == '0) // R3
        else $error("audio not silent while unsynchronised");
    a_fallback_c3: assert property ($past(frame_in.ctrl[CTRL_C3_IDX]) |-> fallback_select) // R7
        else $error("C3 high did not select first carrier");
    a_fallback_unsync: assert property (!s_reg.status[STAT_SYNC_BIT] |-> fallback_select) // R8
        else $error("sync loss did not select first carrier");
    a_err_hold: assert property (!period_end |=> $stable(s_reg.err_reg)) // R9
        else $error("error register changed inside a period");
    a_err_update: assert property (period_end && !sound_error |=> s_reg.err_reg == $past(s_reg.err_cnt)) // R9
        else $error("error register not loaded at period end");
    a_ovw_unread: assert property (aux_store_unread_s |=> s_reg.overwrite_flag && s_reg.new_data) // R12
        else $error("overwrite flag missed");
    a_new_on_store: assert property (aux_in.valid |=> s_reg.new_data ##0 s_reg.aux == $past(aux_in.word)) // R13
        else $error("new data flag or word not stored");
    a_read_clears: assert property (aux_read_s |=> !s_reg.new_data && !s_reg.overwrite_flag) // R24
        else $error("aux read did not clear flags");
    a_pilot_mirror: assert property (s_reg.sif[SIF_PILOT_BIT] == $past(fe_in.pilot)) // R19
        else $error("pilot flag not tracking detector");
    a_reserve_c4: assert property (reserve_switch_flag == $past(frame_in.ctrl[CTRL_C4_IDX])) // R23
        else $error("reserve flag not mirroring C4");
    a_nack_release: assert property (s_reg.st == BUS_MACK && scl_rise && sda_in && !bus_start && !bus_stop // R22
                                     |=> !sda_oe [*2])
        else $error("bus not released after not-acknowledge");
    a_ctrl_mirror: assert property (1'b1 |=> s_reg.status[7:STAT_CTRL_LSB] == $past(frame_in.ctrl)) // R1
        else $error("control bits not mirrored in status");
    a_mode_bits: assert property (1'b1 |=> s_reg.status[STAT_STEREO_BIT] == $past(frame_in.stereo) // R5 R6
                                  && s_reg.status[STAT_DUAL_BIT] == $past(frame_in.dual))
        else $error("stereo or dual mono bit wrong");
    a_cfg_set: assert property (frame_in.cfg_change |=> s_reg.status[STAT_CFG_BIT]) // R4
        else $error("config change not flagged");
    a_cfg_clear: assert property (rd_evt && rd_sub == SUB_STATUS && !frame_in.cfg_change // R4
                                  |=> !s_reg.status[STAT_CFG_BIT])
        else $error("config change flag not cleared by status read");
    a_ci_major: assert property (aux_in.valid |=> s_reg.ci == $past(ci_ref)) // R14
        else $error("coding indicators not majority of parity checks");
    a_audio_pass: assert property (sync_now |=> audio_out == $past(audio_in)) // R3
        else $error("audio not passed while synchronised");
    a_lvl_word: assert property (1'b1 |=> s_reg.lvl == $past(level_word)) // R15 R16
        else $error("level word not captured");
    a_sif_level: assert property (1'b1 |=> s_reg.sif[4:0] == // R17 R18
                                  ($past(fe_in.agc_on) ? $past(fe_in.agc_level) : $past(fe_in.gain_reg)))
        else $error("input level field wrong");
    a_ack_drive: assert property (s_reg.st == BUS_RX && scl_fall && s_reg.full && s_reg.idx == 2'd0 // R22
                                  && s_reg.sh[7:1] == SLAVE_ADDR |=> sda_oe)
        else $error("own address not acknowledged");
    a_tx_release: assert property (tx_last_fall_s |=> !sda_oe && s_reg.st == BUS_MACK // R22
                                   && s_reg.sub == $past(s_reg.sub) + 8'd1)
        else $error("bus not released or subaddress not advanced after a byte");
endmodule

//--- tb/dss_bus_master.sv
// Two-wire bus master model that reads the status bank
`timescale 1ns/100ps
module dss_bus_master #(
    parameter logic [6:0] DEV_ADDR = 7'h5b
) (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_low
);
    logic [7:0] rd_data [0:7];
    int n_nack = 0;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Lines move just after an edge and hold four cycles
    task automatic step(input logic c, input logic low);
        scl <= c;
        sda_low <= low;
        repeat (4) @(posedge clk);
    endtask

    task automatic start_cond();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask

    task automatic stop_cond();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask

    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, !b[i]);
            step(1'b1, !b[i]);
        end
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        if (sda_line !== 1'b0) begin
            n_nack++;
        end
    endtask

    // Acknowledge every byte but the last, which ends the burst
    task automatic recv_byte(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            step(1'b0, 1'b0);
            step(1'b1, 1'b0);
            b[i] = sda_line;
        end
        step(1'b0, !last);
        step(1'b1, !last);
    endtask

    task automatic read_burst(input logic [7:0] sub, input int n);
        @(posedge clk);
        start_cond();
        send_byte({DEV_ADDR, 1'b0});
        send_byte(sub);
        start_cond();
        send_byte({DEV_ADDR, 1'b1});
        for (int i = 0; i < n; i++) begin
            recv_byte(i == n - 1, rd_data[i]);
        end
        stop_cond();
    endtask

    task automatic probe(input logic [7:0] addr);
        @(posedge clk);
        start_cond();
        send_byte(addr);
        stop_cond();
    endtask
endmodule

//--- tb/test_digital_sound_status_readout.sv
// Self-checking bench for the digital sound status readout
`timescale 1ns/100ps
module test_digital_sound_status_readout
    import dss_pkg::*;
();
    localparam int ERR_N = 300;
    // Burst of subaddresses 1..7 after the first setup
    localparam logic [7:0] BURST [7] = '{8'hae, 8'h00, 8'ha3, 8'h15, 8'h8e, 8'h41, 8'h93};
    // {ctrl[3:0], auto fallback, mute request, expected fallback}
    localparam logic [7:0] FB_TAB [6] = '{8'h21, 8'h25, 8'h00, 8'h07, 8'h04, 8'h40};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic scl, sda_low, sda_out, sda_oe, sda_line;
    dss_frame_t frame = '0;
    dss_aux_t aux = '0;
    dss_fe_t fe = '0;
    logic sound_error = 1'b0;
    logic [15:0] level_word = 16'h0000;
    logic [AUDIO_W-1:0] audio_in = 16'h1234;
    logic auto_fallback_config = 1'b0;
    logic auto_mute_req = 1'b0;
    logic [AUDIO_W-1:0] audio_out;
    logic fallback_select, reserve_switch_flag;
    logic [1:0] err_mode = 2'h0;
    logic [1:0] cyc = 2'h0;
    int n_fail = 0;
    int n_compared = 0;

    always #5 clk = ~clk;
    assign sda_line = !((sda_oe && !sda_out) || sda_low);

    // Error source: none, every cycle, or every fourth cycle
    always @(posedge clk) begin
        cyc <= cyc + 2'h1;
        sound_error <= (err_mode == 2'h1) || (err_mode == 2'h2 && cyc == 2'h0);
    end

    dss_readout #(.SLAVE_ADDR(7'h5b), .ERR_PERIOD(ERR_N)) u_dss_readout (
        .clk(clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .frame_in(frame), .sound_error(sound_error), .aux_in(aux), .level_word(level_word), .fe_in(fe),
        .audio_in(audio_in), .auto_fallback_config(auto_fallback_config), .auto_mute_req(auto_mute_req),
        .audio_out(audio_out), .fallback_select(fallback_select), .reserve_switch_flag(reserve_switch_flag)
    );

    dss_bus_master #(.DEV_ADDR(7'h5b)) u_dss_bus_master (
        .clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
    );

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared=%0d mismatches=%0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic rd(input logic [7:0] sub, input logic [7:0] exp);
        u_dss_bus_master.read_burst(sub, 1);
        check({8'h00, u_dss_bus_master.rd_data[0]}, {8'h00, exp});
    endtask

    task automatic pulse_aux(input logic [10:0] w, input logic [9:0] pa, input logic [9:0] pb);
        @(posedge clk);
        aux <= '{valid: 1'b1, word: w, parity_a: pa, parity_b: pb};
        @(posedge clk);
        aux.valid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge clk);
        check(16'(sda_oe), 16'h0000);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        check(16'(fallback_select), 16'h0001);
        check(audio_out, 16'h0000);
        frame <= '{ctrl: 4'ha, frame_lock: 1'b1, mf_lock: 1'b1, cfg_change: 1'b1, stereo: 1'b1, dual: 1'b0};
        level_word <= 16'h8e41;
        fe <= '{agc_on: 1'b1, agc_level: 5'h13, gain_reg: 5'h0a, pilot: 1'b1};
        aux <= '{valid: 1'b1, word: 11'h5a3, parity_a: 10'h3f0, parity_b: 10'h01f};
        @(posedge clk);
        frame.cfg_change <= 1'b0;
        aux.valid <= 1'b0;
        repeat (3) @(posedge clk);
        check(audio_out, 16'h1234);
        u_dss_bus_master.read_burst(8'h01, 7);
        for (int i = 0; i < 7; i++) begin
            check({8'h00, u_dss_bus_master.rd_data[i]}, {8'h00, BURST[i]});
        end
        rd(8'h01, 8'haa);
        frame.mf_lock <= 1'b0;
        repeat (3) @(posedge clk);
        check(16'(fallback_select), 16'h0001);
        check(audio_out, 16'h0000);
        rd(8'h01, 8'ha2);
        frame.mf_lock <= 1'b1;
        frame.stereo <= 1'b0;
        frame.dual <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(posedge clk);
            frame.ctrl <= FB_TAB[i][6:3];
            auto_fallback_config <= FB_TAB[i][2];
            auto_mute_req <= FB_TAB[i][1];
            repeat (3) @(posedge clk);
            check(16'(fallback_select), 16'(FB_TAB[i][0]));
            check(16'(reserve_switch_flag), 16'(FB_TAB[i][6]));
        end
        rd(8'h01, 8'h89);
        pulse_aux(11'h2c7, 10'h000, 10'h3ff);
        pulse_aux(11'h2c7, 10'h000, 10'h3ff);
        rd(8'h04, 8'hca);
        rd(8'h04, 8'h0a);
        pulse_aux(11'h2c7, 10'h000, 10'h3ff);
        rd(8'h04, 8'h4a);
        pulse_aux(11'h2c7, 10'h000, 10'h3ff);
        rd(8'h03, 8'hc7);
        rd(8'h04, 8'h0a);
        fe.agc_on <= 1'b0;
        level_word <= 16'h017f;
        rd(8'h07, 8'h8a);
        fe.pilot <= 1'b0;
        rd(8'h07, 8'h0a);
        u_dss_bus_master.read_burst(8'h05, 2);
        check({8'h00, u_dss_bus_master.rd_data[0]}, 16'h0001);
        check({8'h00, u_dss_bus_master.rd_data[1]}, 16'h007f);
        err_mode <= 2'h2;
        repeat (3 * ERR_N) @(posedge clk);
        rd(8'h02, 8'h4b);
        err_mode <= 2'h1;
        repeat (3 * ERR_N) @(posedge clk);
        rd(8'h02, 8'hff);
        err_mode <= 2'h0;
        repeat (3 * ERR_N) @(posedge clk);
        rd(8'h02, 8'h00);
        check(16'(u_dss_bus_master.n_nack), 16'h0000);
        u_dss_bus_master.probe({7'h2a, 1'b0});
        check(16'(u_dss_bus_master.n_nack), 16'h0001);
        rd(8'h00, SUB_UNMAPPED_VALUE);
        rd(8'h08, SUB_UNMAPPED_VALUE);
        tally_and_finish();
    end
endmodule
